/* File: scr_cmd_response.sv */
/*
  Command decode, response byte and interrupt logic of the light and
  proximity sensor sequencer. Assumes the register port, the sample and
  overflow strobes all come from logic on clk_sys, so none is synchronised.
*/
`timescale 1ns/1ps
`include "scr_defines.svh"

module scr_cmd_response
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire scr_pkg::scr_byte_type reg_addr,
    input wire scr_pkg::scr_byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output scr_pkg::scr_byte_type reg_rdata,
    input wire scr_pkg::scr_irq_vec_type sample_strobe,
    input wire scr_pkg::scr_irq_vec_type overflow_strobe,
    input wire logic invalid_setting_strobe,
    output logic seq_wake,
    output logic prox_loop_run,
    output logic ambient_loop_run,
    output logic prox_loop_restart,
    output logic ambient_loop_restart,
    output logic irq_req,
    output logic int_pin_out,
    output logic int_pin_oe_n
);

    import scr_pkg::*;

    scr_state_type state_reg;
    scr_state_type state_next;

    scr_byte_type int_cfg_reg;
    scr_irq_vec_type irq_enable_reg;
    scr_byte_type policy_first_reg;
    scr_byte_type policy_second_reg;
    scr_byte_type command_reg;
    scr_byte_type response_reg;
    scr_byte_type response_next;
    scr_byte_type rdata_reg;
    scr_byte_type rdata_next;
    scr_irq_vec_type irq_status;
    scr_irq_vec_type status_set;
    scr_irq_vec_type status_clear;

    logic seq_wake_reg;
    logic prox_run_reg;
    logic prox_run_next;
    logic ambient_run_reg;
    logic ambient_run_next;
    logic prox_restart_reg;
    logic ambient_restart_reg;
    logic irq_req_reg;
    logic int_pin_out_reg;
    logic int_pin_oe_n_reg;

    // Register port decode
    logic wr_int_cfg;
    logic wr_irq_enable;
    logic wr_policy_first;
    logic wr_policy_second;
    logic wr_command;
    logic wr_irq_status;

    assign wr_int_cfg = reg_wr && (reg_addr == `SCR_ADDR_INT_CFG);
    assign wr_irq_enable = reg_wr && (reg_addr == `SCR_ADDR_IRQ_ENABLE);
    assign wr_policy_first = reg_wr && (reg_addr == `SCR_ADDR_POLICY_FIRST);
    assign wr_policy_second = reg_wr && (reg_addr == `SCR_ADDR_POLICY_SECOND);
    assign wr_command = reg_wr && (reg_addr == `SCR_ADDR_COMMAND);
    assign wr_irq_status = reg_wr && (reg_addr == `SCR_ADDR_IRQ_STATUS);

    // Command classification, always on the code latched by the last write
    logic exec;
    logic cmd_nop;
    logic cmd_prox_start;
    logic cmd_ambient_start;
    logic cmd_both_start;
    logic cmd_prox_pause;
    logic cmd_ambient_pause;
    logic cmd_both_pause;
    logic cmd_reserved;
    logic cmd_done;
    logic cmd_done_clean;

    assign exec = (state_reg == SCR_EXEC);
    assign cmd_nop = (command_reg == `SCR_CMD_NO_OPERATION);
    assign cmd_prox_start = (command_reg == `SCR_CMD_PROX_LOOP_START);
    assign cmd_ambient_start = (command_reg == `SCR_CMD_AMBIENT_LOOP_START);
    assign cmd_both_start = (command_reg == `SCR_CMD_BOTH_LOOPS_START);
    assign cmd_prox_pause = (command_reg == `SCR_CMD_PROX_PAUSE);
    assign cmd_ambient_pause = (command_reg == `SCR_CMD_AMBIENT_PAUSE);
    assign cmd_both_pause = (command_reg == `SCR_CMD_BOTH_PAUSE);
    assign cmd_reserved = (command_reg[7:5] == 3'h0) && command_reg[4];
    assign cmd_done = exec && !cmd_reserved;
    assign cmd_done_clean = cmd_done && !cmd_nop && (response_reg[7:4] == 4'h0);

    // Error codes; the lowest channel wins when several overflow together
    logic err_event;
    scr_byte_type err_code;

    assign err_event = invalid_setting_strobe || (|overflow_strobe);
    assign err_code =
        invalid_setting_strobe ? `SCR_RESP_INVALID_SETTING :
        overflow_strobe[`SCR_CH_PROX_ONE] ? `SCR_RESP_PROX_ONE_OVERFLOW :
        overflow_strobe[`SCR_CH_PROX_TWO] ? `SCR_RESP_PROX_TWO_OVERFLOW :
        overflow_strobe[`SCR_CH_PROX_THREE] ? `SCR_RESP_PROX_THREE_OVERFLOW :
        overflow_strobe[`SCR_CH_VISIBLE] ? `SCR_RESP_VISIBLE_OVERFLOW :
        overflow_strobe[`SCR_CH_INFRARED] ? `SCR_RESP_INFRARED_OVERFLOW :
        `SCR_RESP_AUX_OVERFLOW;

    // Response byte: an error arriving with a clearing command still sticks
    assign response_next =
        err_event ? err_code :
        (exec && cmd_nop) ? `SCR_RST_BYTE :
        cmd_done_clean ? {4'h0, response_reg[3:0] + 4'h1} :
        response_reg;

    // Measurement loops
    logic start_prox;
    logic start_ambient;
    logic stop_prox;
    logic stop_ambient;

    assign start_prox = exec && (cmd_prox_start || cmd_both_start);
    assign start_ambient = exec && (cmd_ambient_start || cmd_both_start);
    assign stop_prox = exec && (cmd_prox_pause || cmd_both_pause);
    assign stop_ambient = exec && (cmd_ambient_pause || cmd_both_pause);
    assign prox_run_next = start_prox ? 1'b1 : (stop_prox ? 1'b0 : prox_run_reg);
    assign ambient_run_next = start_ambient ? 1'b1 : (stop_ambient ? 1'b0 : ambient_run_reg);

    // Status setting from enable and policy registers
    logic [1:0] ambient_field;
    logic ambient_sample;

    assign ambient_field = irq_enable_reg[`SCR_IRQ_AMBIENT_HI:`SCR_IRQ_AMBIENT_LO];
    assign ambient_sample = sample_strobe[`SCR_CH_VISIBLE] || sample_strobe[`SCR_CH_AUX];

    assign status_set[`SCR_IRQ_AMBIENT_LO] =
        (ambient_field == `SCR_AMBIENT_EVERY_SAMPLE) && ambient_sample;
    // Other ambient modes are threshold based and not built here
    assign status_set[`SCR_IRQ_AMBIENT_HI] = 1'b0;
    assign status_set[`SCR_IRQ_PROX_ONE] = irq_enable_reg[`SCR_IRQ_PROX_ONE]
        && (policy_first_reg[1:0] == `SCR_POLICY_EVERY)
        && sample_strobe[`SCR_CH_PROX_ONE];
    assign status_set[`SCR_IRQ_PROX_TWO] = irq_enable_reg[`SCR_IRQ_PROX_TWO]
        && (policy_first_reg[3:2] == `SCR_POLICY_EVERY)
        && sample_strobe[`SCR_CH_PROX_TWO];
    assign status_set[`SCR_IRQ_PROX_THREE] = irq_enable_reg[`SCR_IRQ_PROX_THREE]
        && (policy_first_reg[5:4] == `SCR_POLICY_EVERY)
        && sample_strobe[`SCR_CH_PROX_THREE];
    // Command interrupt on every completion, or only on errors
    assign status_set[`SCR_IRQ_CMD] = irq_enable_reg[`SCR_IRQ_CMD]
        && ((policy_second_reg[1:0] == `SCR_POLICY_EVERY) ? cmd_done : err_event);

    assign status_clear = wr_irq_status ? reg_wdata[5:0] : `SCR_RST_IRQ_VEC;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1)
        begin : g_flag
            scr_flag_cell u_flag
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .set_pulse(status_set[gi]),
                .clear_pulse(status_clear[gi]),
                .flag(irq_status[gi])
            );
        end
    endgenerate

    // Interrupt pin, active low and driven only while enabled
    logic irq_level;
    logic int_oe;

    assign irq_level = |(irq_enable_reg & irq_status);
    assign int_oe = int_cfg_reg[`SCR_INT_OE_BIT];

    // Read mux; unmapped offsets read as zero
    assign rdata_next =
        !reg_rd ? `SCR_RST_BYTE :
        (reg_addr == `SCR_ADDR_INT_CFG) ? int_cfg_reg :
        (reg_addr == `SCR_ADDR_IRQ_ENABLE) ? {2'h0, irq_enable_reg} :
        (reg_addr == `SCR_ADDR_POLICY_FIRST) ? policy_first_reg :
        (reg_addr == `SCR_ADDR_POLICY_SECOND) ? policy_second_reg :
        (reg_addr == `SCR_ADDR_COMMAND) ? command_reg :
        (reg_addr == `SCR_ADDR_RESPONSE) ? response_reg :
        (reg_addr == `SCR_ADDR_IRQ_STATUS) ? {2'h0, irq_status} :
        `SCR_RST_BYTE;

    // A command runs in the cycle after its write; a write landing during
    // execution simply queues the next one, so none is dropped
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SCR_IDLE:
                state_next = wr_command ? SCR_EXEC : SCR_IDLE;
            SCR_EXEC:
                state_next = wr_command ? SCR_EXEC : SCR_IDLE;
            default:
                state_next = SCR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state_reg <= SCR_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            int_cfg_reg <= `SCR_RST_BYTE;
            irq_enable_reg <= `SCR_RST_IRQ_VEC;
            policy_first_reg <= `SCR_RST_BYTE;
            policy_second_reg <= `SCR_RST_BYTE;
            command_reg <= `SCR_RST_BYTE;
        end
        else
        begin
            if (wr_int_cfg)
                int_cfg_reg <= {7'h00, reg_wdata[`SCR_INT_OE_BIT]};
            if (wr_irq_enable)
                irq_enable_reg <= reg_wdata[5:0];
            if (wr_policy_first)
                policy_first_reg <= reg_wdata;
            if (wr_policy_second)
                policy_second_reg <= reg_wdata;
            if (wr_command)
                command_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            response_reg <= `SCR_RST_BYTE;
            prox_run_reg <= 1'b0;
            ambient_run_reg <= 1'b0;
            prox_restart_reg <= 1'b0;
            ambient_restart_reg <= 1'b0;
            seq_wake_reg <= 1'b0;
        end
        else
        begin
            response_reg <= response_next;
            prox_run_reg <= prox_run_next;
            ambient_run_reg <= ambient_run_next;
            prox_restart_reg <= start_prox;
            ambient_restart_reg <= start_ambient;
            seq_wake_reg <= wr_command;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_reg <= `SCR_RST_BYTE;
            irq_req_reg <= 1'b0;
            int_pin_out_reg <= 1'b1;
            int_pin_oe_n_reg <= 1'b1;
        end
        else
        begin
            rdata_reg <= rdata_next;
            irq_req_reg <= irq_level;
            int_pin_out_reg <= !irq_level;
            int_pin_oe_n_reg <= !(int_oe && irq_level);
        end
    end

    assign reg_rdata = rdata_reg;
    assign seq_wake = seq_wake_reg;
    assign prox_loop_run = prox_run_reg;
    assign ambient_loop_run = ambient_run_reg;
    assign prox_loop_restart = prox_restart_reg;
    assign ambient_loop_restart = ambient_restart_reg;
    assign irq_req = irq_req_reg;
    assign int_pin_out = int_pin_out_reg;
    assign int_pin_oe_n = int_pin_oe_n_reg;

endmodule // scr_cmd_response

/* File: scr_defines.svh */
/*
  Constants of the sensor command and response block: register offsets,
  command codes, response codes, field positions and reset values.
  Assumes it is included by bare name from the modules that use it.
*/
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// Register offsets on the byte-wide register port
`define SCR_ADDR_INT_CFG 8'h03
`define SCR_ADDR_IRQ_ENABLE 8'h04
`define SCR_ADDR_POLICY_FIRST 8'h05
`define SCR_ADDR_POLICY_SECOND 8'h06
`define SCR_ADDR_COMMAND 8'h18
`define SCR_ADDR_RESPONSE 8'h20
`define SCR_ADDR_IRQ_STATUS 8'h21

// Command codes
`define SCR_CMD_NO_OPERATION 8'h00
`define SCR_CMD_PROX_PAUSE 8'h09
`define SCR_CMD_AMBIENT_PAUSE 8'h0a
`define SCR_CMD_BOTH_PAUSE 8'h0b
`define SCR_CMD_PROX_LOOP_START 8'h0d
`define SCR_CMD_AMBIENT_LOOP_START 8'h0e
`define SCR_CMD_BOTH_LOOPS_START 8'h0f

// Response codes
`define SCR_RESP_INVALID_SETTING 8'h80
`define SCR_RESP_PROX_ONE_OVERFLOW 8'h88
`define SCR_RESP_PROX_TWO_OVERFLOW 8'h89
`define SCR_RESP_PROX_THREE_OVERFLOW 8'h8a
`define SCR_RESP_VISIBLE_OVERFLOW 8'h8c
`define SCR_RESP_INFRARED_OVERFLOW 8'h8d
`define SCR_RESP_AUX_OVERFLOW 8'h8e

// Channel index of sample and overflow strobes
`define SCR_CH_PROX_ONE 0
`define SCR_CH_PROX_TWO 1
`define SCR_CH_PROX_THREE 2
`define SCR_CH_VISIBLE 3
`define SCR_CH_INFRARED 4
`define SCR_CH_AUX 5

// Interrupt enable and status bit positions, ambient and policy field codes and pin enable bit
`define SCR_IRQ_AMBIENT_LO 0
`define SCR_IRQ_AMBIENT_HI 1
`define SCR_IRQ_PROX_ONE 2
`define SCR_IRQ_PROX_TWO 3
`define SCR_IRQ_PROX_THREE 4
`define SCR_IRQ_CMD 5
`define SCR_AMBIENT_EVERY_SAMPLE 2'b01
`define SCR_POLICY_EVERY 2'b00
`define SCR_INT_OE_BIT 0

// Reset values
`define SCR_RST_BYTE 8'h00
`define SCR_RST_IRQ_VEC 6'h00

`endif

/* File: scr_pkg.sv */
/*
  Types shared by the sensor command and response block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scr_pkg;

    typedef logic [7:0] scr_byte_type;
    typedef logic [5:0] scr_irq_vec_type;

    typedef enum logic [1:0] {
        SCR_IDLE = 2'b01,
        SCR_EXEC = 2'b10
    } scr_state_type;

endpackage

/* File: scr_flag_cell.sv */
/*
  One sticky interrupt status bit: set by a hardware event, cleared by
  software writing a one. Assumes set and clear come from logic on clk_sys.
*/
`timescale 1ns/1ps

module scr_flag_cell
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic set_pulse,
    input wire logic clear_pulse,
    output logic flag
);

    logic flag_reg;
    logic flag_next;

    // An event in the clearing cycle must not be lost, so set wins
    assign flag_next = set_pulse ? 1'b1 : (clear_pulse ? 1'b0 : flag_reg);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    assign flag = flag_reg;

endmodule // scr_flag_cell

/* File: scr_cmd_response_sva.sv */
/*
  Checker of the command and response block: relations between its ports.
  Assumes it is bound to scr_cmd_response and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "scr_defines.svh"

module scr_cmd_response_chk
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire scr_pkg::scr_byte_type reg_addr,
    input wire scr_pkg::scr_byte_type reg_wdata,
    input wire logic reg_wr,
    input wire scr_pkg::scr_irq_vec_type sample_strobe,
    input wire scr_pkg::scr_irq_vec_type overflow_strobe,
    input wire logic invalid_setting_strobe,
    input wire logic seq_wake,
    input wire logic prox_loop_run,
    input wire logic ambient_loop_run,
    input wire logic prox_loop_restart,
    input wire logic ambient_loop_restart,
    input wire logic irq_req,
    input wire logic int_pin_out,
    input wire logic int_pin_oe_n
);
    import scr_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    wire cmd_wr = reg_wr && (reg_addr == `SCR_ADDR_COMMAND);
    wire stat_clr_all = reg_wr && (reg_addr == `SCR_ADDR_IRQ_STATUS)
        && (reg_wdata[5:0] == 6'h3f);
    // Any event in the clearing cycle may set a bit again, so it must be quiet
    wire quiet = (sample_strobe == 6'h00) && (overflow_strobe == 6'h00) && !invalid_setting_strobe;

    a_wake_on_cmd: assert property (cmd_wr |=> seq_wake)
        else $error("seq_wake missing after command write");
    a_no_stray_wake: assert property (!cmd_wr |=> !seq_wake)
        else $error("seq_wake without command write");
    a_prox_start: assert property (cmd_wr && reg_wdata == 8'h0d
        |=> ##1 prox_loop_run && prox_loop_restart)
        else $error("proximity loop did not start");
    a_ambient_start: assert property (cmd_wr && reg_wdata == 8'h0e
        |=> ##1 ambient_loop_run && ambient_loop_restart)
        else $error("ambient loop did not start");
    a_reserved_quiet: assert property (cmd_wr && reg_wdata[7:4] == 4'h1
        |=> ##1 !prox_loop_restart && !ambient_loop_restart)
        else $error("reserved command restarted a loop");
    a_pin_value: assert property (int_pin_out == !irq_req)
        else $error("pin value disagrees with interrupt level");
    a_oe_gated: assert property (!int_pin_oe_n |-> irq_req)
        else $error("pin driven without pending interrupt");
    a_irq_cleared: assert property (stat_clr_all && quiet && !seq_wake
        |=> ##1 !irq_req)
        else $error("interrupt still high after full clear");
endmodule // scr_cmd_response_chk

/* File: scr_host_model.sv */
/*
  Host side model: register port master with write, read and service tasks.
  Assumes the tasks are called one at a time from the testbench.
*/
`timescale 1ns/1ps

module scr_host_model
(
    input wire logic clk_sys,
    input wire scr_pkg::scr_byte_type reg_rdata,
    output scr_pkg::scr_byte_type reg_addr,
    output scr_pkg::scr_byte_type reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    import scr_pkg::*;
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines show the inverse so stale values never look valid
    task automatic wr(input scr_byte_type a, input scr_byte_type d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input scr_byte_type a, output scr_byte_type d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    task automatic service(output scr_byte_type v);
        rd(8'h21, v);
        wr(8'h21, v);
    endtask

    task automatic init_irq(input scr_byte_type en);
        wr(8'h04, en);
        wr(8'h03, 8'h01);
    endtask
endmodule // scr_host_model

/* File: tb_scr_cmd_response.sv */
/*
  Self-checking testbench of the command and response block.
  Assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/1ps
`include "scr_defines.svh"

module tb_scr_cmd_response;
    import scr_pkg::*;
    logic clk_sys, rst_n, invalid_setting_strobe, cfg, prun, arun;
    logic seq_wake, prox_loop_run, ambient_loop_run, prox_loop_restart, ambient_loop_restart;
    logic irq_req, int_pin_out, int_pin_oe_n, reg_wr, reg_rd;
    scr_byte_type reg_addr, reg_wdata, reg_rdata, rv, code, en;
    scr_irq_vec_type sample_strobe, overflow_strobe, sv, ex;
    integer seed = 74, miscompares = 0, check_count = 0, i, k;
    logic [3:0] cnt;
    scr_byte_type cmd_tab [7] = '{8'h0d, 8'h0e, 8'h0f, 8'h09, 8'h0a, 8'h0b, 8'h00};
    scr_byte_type err_tab [7] = '{8'h80, 8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d, 8'h8e};
    // Open-drain line with a pull-up
    wire int_line = int_pin_oe_n ? 1'b1 : int_pin_out;

    scr_cmd_response uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_strobe(sample_strobe), .overflow_strobe(overflow_strobe),
        .invalid_setting_strobe(invalid_setting_strobe), .seq_wake(seq_wake),
        .prox_loop_run(prox_loop_run), .ambient_loop_run(ambient_loop_run),
        .prox_loop_restart(prox_loop_restart), .ambient_loop_restart(ambient_loop_restart),
        .irq_req(irq_req), .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n));
    scr_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle pulse on the sample and overflow strobes
    task automatic pulse(input scr_irq_vec_type s, input scr_irq_vec_type o);
        @(posedge clk_sys);
        sample_strobe <= s;
        overflow_strobe <= o;
        @(posedge clk_sys);
        sample_strobe <= 6'h00;
        overflow_strobe <= 6'h00;
    endtask

    function automatic scr_irq_vec_type exp_status(input scr_irq_vec_type s);
        return {1'b0, s[2], s[1], s[0], 1'b0, s[3] | s[5]};
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        rst_n = 1'b0;
        sample_strobe = 6'h00;
        overflow_strobe = 6'h00;
        invalid_setting_strobe = 1'b0;
        cnt = 4'h0;
        prun = 1'b0;
        arun = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        host.rd(`SCR_ADDR_RESPONSE, rv);
        chk(rv, 8'h00, "response after reset");
        chk({7'h00, int_line}, 8'h01, "pin released after reset");
        // Random commands, reserved codes among them; counter wraps past 15
        for (i = 0; i < 24; i++)
        begin
            k = $random(seed);
            code = (k[2:0] == 3'h7) ? {4'h1, k[7:4]} : cmd_tab[k[2:0]];
            host.wr(`SCR_ADDR_COMMAND, code);
            if (code == 8'h00)
                cnt = 4'h0;
            else if (code[7:4] == 4'h0)
                cnt++;
            case (code)
                8'h0d: prun = 1'b1;
                8'h0e: arun = 1'b1;
                8'h0f: {prun, arun} = 2'b11;
                8'h09: prun = 1'b0;
                8'h0a: arun = 1'b0;
                8'h0b: {prun, arun} = 2'b00;
                default: ;
            endcase
            host.rd(`SCR_ADDR_RESPONSE, rv);
            chk(rv, {4'h0, cnt}, "response counter");
            rv = {6'h00, prox_loop_run, ambient_loop_run};
            chk(rv, {6'h00, prun, arun}, "loops");
        end
        // Each error, then a command that must not bump the counter
        for (i = 0; i < 7; i++)
        begin
            @(posedge clk_sys);
            invalid_setting_strobe <= (i == 0);
            overflow_strobe <= (i == 0) ? 6'h00 : scr_irq_vec_type'(1 << (i - 1));
            @(posedge clk_sys);
            invalid_setting_strobe <= 1'b0;
            overflow_strobe <= 6'h00;
            host.wr(`SCR_ADDR_COMMAND, 8'h0d);
            host.rd(`SCR_ADDR_RESPONSE, rv);
            chk(rv, err_tab[i], "error code");
            host.wr(`SCR_ADDR_COMMAND, 8'h00);
            host.rd(`SCR_ADDR_RESPONSE, rv);
            chk(rv, 8'h00, "error cleared");
        end
        // Random masks, pin enable and sample bursts
        for (i = 0; i < 16; i++)
        begin
            k = $random(seed);
            sv = k[5:0];
            cfg = k[6];
            en = k[15:8] & 8'h1d;
            ex = exp_status(sv) & en[5:0];
            host.init_irq(en);
            host.wr(`SCR_ADDR_INT_CFG, {7'h00, cfg});
            @(posedge clk_sys);
            sample_strobe <= sv;
            @(posedge clk_sys);
            sample_strobe <= 6'h00;
            repeat (2) @(posedge clk_sys);
            #1;
            chk({7'h00, irq_req}, {7'h00, ex != 6'h00}, "irq level");
            chk({7'h00, int_line}, {7'h00, !(cfg && ex != 6'h00)}, "pin level");
            host.wr(`SCR_ADDR_IRQ_STATUS, 8'h00);
            host.rd(`SCR_ADDR_IRQ_STATUS, rv);
            chk(rv, {2'b00, ex}, "status kept");
            host.service(rv);
            host.rd(`SCR_ADDR_IRQ_STATUS, rv);
            chk(rv, 8'h00, "status cleared");
        end
        // Command interrupt under both policies, a held-off proximity policy,
        // and a sample landing in the clearing cycle
        host.init_irq(8'h24);
        host.wr(`SCR_ADDR_COMMAND, 8'h0e);
        host.rd(`SCR_ADDR_IRQ_STATUS, rv);
        chk(rv, 8'h20, "command status on completion");
        host.service(rv);
        host.wr(`SCR_ADDR_POLICY_SECOND, 8'h01);
        host.wr(`SCR_ADDR_COMMAND, 8'h0d);
        host.rd(`SCR_ADDR_IRQ_STATUS, rv);
        chk(rv, 8'h00, "command status without error");
        pulse(6'h00, 6'h01);
        host.rd(`SCR_ADDR_IRQ_STATUS, rv);
        chk(rv, 8'h20, "command status on error");
        host.service(rv);
        host.wr(`SCR_ADDR_POLICY_FIRST, 8'h01);
        pulse(6'h01, 6'h00);
        host.rd(`SCR_ADDR_IRQ_STATUS, rv);
        chk(rv, 8'h00, "proximity policy held off");
        host.wr(`SCR_ADDR_POLICY_FIRST, 8'h00);
        fork
            host.wr(`SCR_ADDR_IRQ_STATUS, 8'h04);
            pulse(6'h01, 6'h00);
        join
        host.rd(`SCR_ADDR_IRQ_STATUS, rv);
        chk(rv, 8'h04, "set beats clear");
        chk({7'h00, irq_req}, 8'h01, "irq pending");
        host.wr(`SCR_ADDR_IRQ_STATUS, 8'h3f);
        @(posedge clk_sys);
        #1;
        chk({7'h00, irq_req}, 8'h00, "irq after full clear");
        host.wr(`SCR_ADDR_IRQ_STATUS, 8'hff);
        repeat (3) @(posedge clk_sys);
        end_sim;
    end

    initial
    begin
        #100000;
        miscompares++;
        end_sim;
    end
endmodule // tb_scr_cmd_response

bind scr_cmd_response scr_cmd_response_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .sample_strobe(sample_strobe), .overflow_strobe(overflow_strobe),
    .invalid_setting_strobe(invalid_setting_strobe), .seq_wake(seq_wake),
    .prox_loop_run(prox_loop_run), .ambient_loop_run(ambient_loop_run),
    .prox_loop_restart(prox_loop_restart), .ambient_loop_restart(ambient_loop_restart),
    .irq_req(irq_req), .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n));
